// ===== rtl/paired_word_vector_alu_ops.sv
/*
 Two-lane 64-bit vector execution block: word divide, equivalence, sign
 extension, float absolute value, float add and fraction conversion.
 Assumes an AHB-Lite master with single word transfers and one slave.
*/
//
// Overview of operation
// - signed divide per lane, quotients only
// - zero divisor, negative dividend: 0x80000000, overflow
// - zero divisor, non-negative dividend: 0x7FFFFFFF, overflow
// - most negative over minus one saturates positive
// - divides always write overflow and sticky flags
// - unsigned divide per lane, quotients only
// - unsigned zero divisor gives all ones, overflow
// - equivalence writes bitwise XNOR
// - sign extend low byte of each lane
// - sign extend low halfword of each lane
// - absolute value clears sign bit
// - absolute value is a sign-bit operation
// - absolute value flags invalid, may interrupt
// - add: NaN or infinity gives signed max
// - add: overflow max, underflow zero by mode
// - add: invalid inputs flag, interrupt when enabled
// - add: overflow/underflow flags, interrupt when enabled
// - inexact sticky set when no invalid or overflow/underflow interrupt taken
// - inexact enabled: round interrupt, truncated results
// - guard and sticky cleared on invalid lanes and overflow/underflow interrupts
// - convert signed fraction to single precision
`include "vec_alu_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module paired_word_vector_alu_ops
	import vec_alu_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             fp_irq,
	output logic             round_irq,
	output logic             busy
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Round-up decision for a truncated magnitude
	function automatic logic rnd_up(input logic s, lsb, g, x, input logic [1:0] rnd_mode);
		case (rmode_t'(rnd_mode))
			round_nearest_mode:      rnd_up = g & (x | lsb);
			round_toward_plus_mode:  rnd_up = ~s & (g | x);
			round_toward_minus_mode: rnd_up = s & (g | x);
			default:                 rnd_up = 1'b0;
		endcase
	endfunction

	// Single-precision add of normal or zero operands
	function automatic fp_res_t fp_add(input logic [31:0] a, b, input logic [1:0] rnd_mode);
		logic [31:0]      p, q;
		logic [7:0]       d;
		logic [26:0]      mp, mq, sh;
		logic [27:0]      s;
		logic [4:0]       lz;
		logic             f, up;
		logic signed [9:0] e, er;
		logic [24:0]      mr;
		fp_res_t          r;
		r = '0;
		f = 1'b0;
		lz = 5'h00;
		if (a[30:0] >= b[30:0]) begin
			p = a;
			q = b;
		end else begin
			p = b;
			q = a;
		end
		mp = {|p[30:23], p[22:0], 3'h0};
		mq = {|q[30:23], q[22:0], 3'h0};
		d = p[30:23] - q[30:23];
		sh = (d > 8'd26) ? 27'h0 : (mq >> d);
		sh[0] = sh[0] | ((d > 8'd26) ? |mq : |(mq & ~(sh << d)));
		s = (p[31] == q[31]) ? {1'b0, mp} + {1'b0, sh} : {1'b0, mp} - {1'b0, sh};
		e = $signed({2'h0, p[30:23]});
		if (s[27]) begin
			s = {1'b0, s[27:2], s[1] | s[0]};
			e = e + 10'sh001;
		end else begin
			for (int i = 26; i >= 0; i--) begin
				if (!f && s[i]) f = 1'b1;
				else if (!f) lz = lz + 5'h01;
			end
			s = s << lz;
			e = e - $signed({5'h00, lz});
		end
		r.grd = s[2];
		r.sx = |s[1:0];
		r.inx = r.grd | r.sx;
		up = rnd_up(p[31], s[3], s[2], r.sx, rnd_mode);
		mr = {1'b0, s[26:3]} + {24'h0, up};
		er = e + $signed({9'h000, mr[24]});
		r.trunc = {p[31], e[7:0], s[25:3]};
		if (s == 28'h0) begin
			r.res = {rnd_mode == 2'h3, 31'h0};
			r.trunc = r.res;
		end else if (er >= 10'sh0ff) begin
			r.ovf = 1'b1;
			r.res = {p[31], `FP_PMAX};
		end else if (e <= 10'sh000) begin
			r.unf = 1'b1;
			r.res = {rnd_mode == 2'h3, 31'h0};
		end else begin
			r.res = {p[31], er[7:0], mr[24] ? mr[23:1] : mr[22:0]};
		end
		return r;
	endfunction

	// Signed 1.31 fraction to single precision
	function automatic logic [31:0] cnv_frac(input logic [31:0] x,
		input logic [1:0] rnd_mode);
		logic [31:0]      m;
		logic [4:0]       lz;
		logic             f;
		logic [24:0]      mr;
		logic signed [9:0] e;
		f = 1'b0;
		lz = 5'h00;
		m = x[31] ? 32'(-x) : x;
		for (int i = 31; i >= 0; i--) begin
			if (!f && m[i]) f = 1'b1;
			else if (!f) lz = lz + 5'h01;
		end
		m = m << lz;
		mr = {1'b0, m[31:8]} + {24'h0, rnd_up(x[31], m[8], m[7], |m[6:0], rnd_mode)};
		e = `FP_BIAS - $signed({5'h00, lz}) + $signed({9'h000, mr[24]});
		if (x == 32'h0) return 32'h0;
		return {x[31], e[7:0], mr[24] ? mr[23:1] : mr[22:0]};
	endfunction

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	ahb_ap_t     ap_q;
	vec_t        opa_q, opb_q, src_a_q, src_b_q, res_q, res_d;
	lane_flags_t [1:0] fl_q, fl_d;
	logic [7:0]  ctrl_q;
	op_t         op_q;
	state_t      state_q;
	logic [5:0]  cnt_q;
	logic        fp_irq_d, rnd_irq_d, commit;
	logic        wr_dp, start;
	logic [31:0] rd_mux;

	assign wr_dp  = ap_q.sel & ap_q.wr;
	assign start  = wr_dp && ap_q.addr == `A_CMD && state_q == ST_IDLE;
	assign commit = state_q == ST_DONE;

	// Address phase capture, zero wait, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_q      <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ap_q.sel  <= hsel & htrans[1] & hready;
			ap_q.wr   <= hwrite;
			ap_q.addr <= {haddr[7:2], 2'h0};
		end
	end

	// Read data is prepared in the address phase
	always_comb begin
		case ({haddr[7:2], 2'h0})
			`A_OPA_HI: rd_mux = opa_q[1];
			`A_OPA_LO: rd_mux = opa_q[0];
			`A_OPB_HI: rd_mux = opb_q[1];
			`A_OPB_LO: rd_mux = opb_q[0];
			`A_CMD:    rd_mux = {29'h0, op_q};
			`A_RES_HI: rd_mux = res_q[1];
			`A_RES_LO: rd_mux = res_q[0];
			`A_SCR:    rd_mux = {8'h00, fl_q[1], ctrl_q, fl_q[0]};
			`A_STAT:   rd_mux = {29'h0, state_q};
			default:   rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) hrdata <= 32'h0;
		else if (hsel & htrans[1] & hready & ~hwrite) hrdata <= rd_mux;
	end

	// Operand and control writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opa_q  <= '0;
			opb_q  <= '0;
			ctrl_q <= `CTRL_RST;
		end else if (wr_dp) begin
			case (ap_q.addr)
				`A_OPA_HI: opa_q[1] <= hwdata;
				`A_OPA_LO: opa_q[0] <= hwdata;
				`A_OPB_HI: opb_q[1] <= hwdata;
				`A_OPB_LO: opb_q[0] <= hwdata;
				`A_SCR:    ctrl_q <= hwdata[15:8];
				default:   ctrl_q <= ctrl_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			cnt_q   <= 6'h00;
			op_q    <= OP_DIVS;
			src_a_q <= '0;
			src_b_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: if (start) begin
					op_q    <= op_t'(hwdata[2:0]);
					src_a_q <= opa_q;
					src_b_q <= opb_q;
					cnt_q   <= `DIV_STEPS;
					state_q <= (hwdata[2:1] == 2'h0) ? ST_DIV : ST_DONE;
				end
				ST_DIV: begin
					cnt_q <= cnt_q - 6'h01;
					if (cnt_q == 6'h01) state_q <= ST_DONE;
				end
				ST_DONE: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Restoring divider, both lanes in step
	// ------------------------------------------------------------
	logic [1:0][31:0] rem_q, quo_q, dv_q, na, nb;
	logic [1:0][32:0] t;
	logic             sgn_start;

	assign sgn_start = hwdata[2:0] == OP_DIVS;

	always_comb begin
		for (int l = 0; l < 2; l++) begin
			na[l] = (sgn_start && opa_q[l][31]) ? 32'(-opa_q[l]) : opa_q[l];
			nb[l] = (sgn_start && opb_q[l][31]) ? 32'(-opb_q[l]) : opb_q[l];
			t[l]  = {rem_q[l], quo_q[l][31]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rem_q <= '0;
			quo_q <= '0;
			dv_q  <= '0;
		end else begin
			for (int l = 0; l < 2; l++) begin
				if (start) begin
					rem_q[l] <= 32'h0;
					quo_q[l] <= na[l];
					dv_q[l]  <= nb[l];
				end else if (state_q == ST_DIV) begin
					if (t[l] >= {1'b0, dv_q[l]}) begin
						rem_q[l] <= 32'(t[l] - {1'b0, dv_q[l]});
						quo_q[l] <= {quo_q[l][30:0], 1'b1};
					end else begin
						rem_q[l] <= t[l][31:0];
						quo_q[l] <= {quo_q[l][30:0], 1'b0};
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Result and flag commit
	// ------------------------------------------------------------
	fp_res_t [1:0] fa;
	logic [1:0]    inv, spec_a, spec_b;
	logic [1:0]    rnd_mode;

	assign rnd_mode = ctrl_q[`CTRL_RND_LSB +: 2];

	always_comb begin
		for (int l = 0; l < 2; l++) begin
			spec_a[l] = &src_a_q[l][30:23];
			spec_b[l] = &src_b_q[l][30:23];
			inv[l] = spec_a[l] | (~|src_a_q[l][30:23] & |src_a_q[l][22:0]);
			if (op_q == OP_ADD)
				inv[l] = inv[l] | spec_b[l] | (~|src_b_q[l][30:23] & |src_b_q[l][22:0]);
			fa[l] = fp_add(src_a_q[l], src_b_q[l], rnd_mode);
			if (spec_a[l]) fa[l].res = {src_a_q[l][31], `FP_PMAX};
			else if (spec_b[l]) fa[l].res = {src_b_q[l][31], `FP_PMAX};
			if (spec_a[l] | spec_b[l]) fa[l].trunc = fa[l].res;
		end
	end

	always_comb begin
		res_d = res_q;
		fl_d = fl_q;
		fp_irq_d = 1'b0;
		rnd_irq_d = 1'b0;
		case (op_q)
			OP_DIVS, OP_DIVU: begin
				for (int l = 0; l < 2; l++) begin
					fl_d[l].quo_sat = 1'b0;
					res_d[l] = quo_q[l];
					if (op_q == OP_DIVU && src_b_q[l] == 32'h0) begin
						res_d[l] = `Q_U_SAT;
						fl_d[l].quo_sat = 1'b1;
					end else if (op_q == OP_DIVS) begin
						if (src_a_q[l][31] ^ src_b_q[l][31])
							res_d[l] = 32'(-quo_q[l]);
						if (src_b_q[l] == 32'h0) begin
							res_d[l] = src_a_q[l][31] ? `Q_NEG_SAT : `Q_POS_SAT;
							fl_d[l].quo_sat = 1'b1;
						end else if (src_a_q[l] == `Q_NEG_SAT && src_b_q[l] == `Q_U_SAT) begin
							res_d[l] = `Q_POS_SAT;
							fl_d[l].quo_sat = 1'b1;
						end
					end
					fl_d[l].quo_sat_sticky = fl_q[l].quo_sat_sticky | fl_d[l].quo_sat;
				end
			end
			OP_EQV:   res_d = ~(src_a_q ^ src_b_q);
			OP_EXTSB: for (int l = 0; l < 2; l++)
				res_d[l] = {{24{src_a_q[l][7]}}, src_a_q[l][7:0]};
			OP_EXTSH: for (int l = 0; l < 2; l++)
				res_d[l] = {{16{src_a_q[l][15]}}, src_a_q[l][15:0]};
			OP_CFSF:  for (int l = 0; l < 2; l++)
				res_d[l] = cnv_frac(src_b_q[l], rnd_mode);
			OP_ABS, OP_ADD: begin
				for (int l = 0; l < 2; l++) begin
					fl_d[l].inv = inv[l];
					if (inv[l]) begin
						fl_d[l].grd = 1'b0;
						fl_d[l].sx = 1'b0;
					end
				end
				if (|inv && ctrl_q[`CTRL_INV_EN]) begin
					fp_irq_d = 1'b1;
				end else if (op_q == OP_ABS) begin
					for (int l = 0; l < 2; l++)
						res_d[l] = {1'b0, src_a_q[l][30:0]};
				end else begin
					for (int l = 0; l < 2; l++) begin
						fl_d[l].ovf = fa[l].ovf & ~inv[l];
						fl_d[l].unf = fa[l].unf & ~inv[l];
					end
					if ((ctrl_q[`CTRL_OVF_EN] && (fl_d[1].ovf | fl_d[0].ovf)) ||
					    (ctrl_q[`CTRL_UNF_EN] && (fl_d[1].unf | fl_d[0].unf))) begin
						fp_irq_d = 1'b1;
						for (int l = 0; l < 2; l++) begin
							fl_d[l].grd = 1'b0;
							fl_d[l].sx = 1'b0;
						end
					end else begin
						for (int l = 0; l < 2; l++) begin
							if (!inv[l]) begin
								fl_d[l].grd = fa[l].grd;
								fl_d[l].sx = fa[l].sx;
								if (fa[l].inx | fa[l].ovf | fa[l].unf)
									fl_d[l].inxs = 1'b1;
							end
							res_d[l] = fa[l].res;
						end
						if (ctrl_q[`CTRL_INX_EN] && (fl_d[1].inxs & ~fl_q[1].inxs |
						    fl_d[0].inxs & ~fl_q[0].inxs | (|inv == 1'b0 &&
						    (fa[1].inx | fa[0].inx)))) begin
							rnd_irq_d = 1'b1;
							for (int l = 0; l < 2; l++)
								res_d[l] = fa[l].trunc;
						end
					end
				end
			end
			default: res_d = res_q;
		endcase
	end

	// Result, flags and event outputs; hardware update wins over software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_q     <= '0;
			fl_q      <= '0;
			fp_irq    <= 1'b0;
			round_irq <= 1'b0;
			busy      <= 1'b0;
		end else begin
			fp_irq    <= commit & fp_irq_d;
			round_irq <= commit & rnd_irq_d;
			busy      <= start | (state_q == ST_DIV) | (commit & 1'b0);
			if (commit) begin
				res_q <= res_d;
				fl_q  <= fl_d;
			end else if (wr_dp && ap_q.addr == `A_SCR) begin
				fl_q[0] <= hwdata[7:0];
				fl_q[1] <= hwdata[23:16];
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence div_started;
		state_q == ST_IDLE ##1 state_q == ST_DIV;
	endsequence
	sequence div_finishes;
		(state_q == ST_DIV) [*8] ##[20:30] state_q == ST_DONE;
	endsequence

	div_length_a: assert property (div_started |-> div_finishes)
		else $error("divide did not finish in 32 steps");
	divs_negzero_a: assert property (commit && op_q == OP_DIVS && src_b_q[0] == 32'h0 &&
		src_a_q[0][31] |=> res_q[0] == 32'h80000000 && fl_q[0].quo_sat)
		else $error("signed zero divide negative wrong");
	divs_poszero_a: assert property (commit && op_q == OP_DIVS && src_b_q[1] == 32'h0 &&
		!src_a_q[1][31] |=> res_q[1] == 32'h7fffffff && fl_q[1].quo_sat)
		else $error("signed zero divide positive wrong");
	divs_minneg_a: assert property (commit && op_q == OP_DIVS && src_a_q[0] == 32'h80000000 &&
		src_b_q[0] == 32'hffffffff |=> res_q[0] == 32'h7fffffff)
		else $error("most negative over minus one wrong");
	div_sticky_a: assert property (commit && op_q inside {OP_DIVS, OP_DIVU} |=>
		fl_q[0].quo_sat_sticky == ($past(fl_q[0].quo_sat_sticky) | fl_q[0].quo_sat))
		else $error("sticky overflow not accumulated");
	divu_zero_a: assert property (commit && op_q == OP_DIVU && src_b_q[1] == 32'h0 |=>
		res_q[1] == 32'hffffffff && fl_q[1].quo_sat_sticky)
		else $error("unsigned zero divide wrong");
	eqv_value_a: assert property (commit && op_q == OP_EQV |=>
		res_q == ~($past(src_a_q) ^ $past(src_b_q)))
		else $error("equivalence wrong");
	extsb_value_a: assert property (commit && op_q == OP_EXTSB |=>
		$signed(res_q[1]) == $signed($past(src_a_q[1][7:0])))
		else $error("byte sign extension wrong");
	abs_sign_a: assert property (commit && op_q == OP_ABS && !fp_irq_d |=>
		!res_q[1][31] && !res_q[0][31] && res_q[0][30:0] == $past(src_a_q[0][30:0]))
		else $error("absolute value wrong");
	inv_hold_a: assert property (commit && op_q == OP_ADD && |inv && ctrl_q[0] |=>
		fp_irq && $stable(res_q) && fl_q[1].inv == $past(inv[1]))
		else $error("invalid add updated destination");

endmodule

`default_nettype wire

// ===== rtl/vec_alu_cfg.svh
/*
 Register offsets, field positions, reset values and fixed constants of the
 paired-word vector execution block. Assumes inclusion by bare name.
*/
`ifndef VEC_ALU_CFG_SVH
`define VEC_ALU_CFG_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define A_OPA_HI    8'h00
`define A_OPA_LO    8'h04
`define A_OPB_HI    8'h08
`define A_OPB_LO    8'h0c
`define A_CMD       8'h10
`define A_RES_HI    8'h14
`define A_RES_LO    8'h18
`define A_SCR       8'h1c
`define A_STAT      8'h20

// ------------------------------------------------------------
// Control byte of the status/control register (bits 15:8)
// ------------------------------------------------------------
`define CTRL_INV_EN 0
`define CTRL_OVF_EN 1
`define CTRL_UNF_EN 2
`define CTRL_INX_EN 3
`define CTRL_RND_LSB 4
`define CTRL_RST    8'h00

// ------------------------------------------------------------
// Datapath constants
// ------------------------------------------------------------
`define DIV_STEPS   6'd32
`define FP_PMAX     31'h7f7fffff
`define Q_NEG_SAT   32'h80000000
`define Q_POS_SAT   32'h7fffffff
`define Q_U_SAT     32'hffffffff
`define FP_BIAS     10'sh07f

`endif

// ===== rtl/vec_alu_pkg.sv
/*
 Types of the paired-word vector execution block.
 Assumes the configuration header is compiled alongside.
*/
package vec_alu_pkg;

	// Operation codes written to the command register
	typedef enum logic [2:0] {
		OP_DIVS  = 3'h0,
		OP_DIVU  = 3'h1,
		OP_EQV   = 3'h2,
		OP_EXTSB = 3'h3,
		OP_EXTSH = 3'h4,
		OP_ABS   = 3'h5,
		OP_ADD   = 3'h6,
		OP_CFSF  = 3'h7
	} op_t;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DIV  = 3'b010,
		ST_DONE = 3'b100
	} state_t;

	// Rounding modes
	typedef enum logic [1:0] {
		round_nearest_mode      = 2'h0,
		round_toward_zero_mode  = 2'h1,
		round_toward_plus_mode  = 2'h2,
		round_toward_minus_mode = 2'h3
	} rmode_t;

	// Per-lane status flags, bit 7 first
	typedef struct packed {
		logic inxs;
		logic unf;
		logic ovf;
		logic sx;
		logic grd;
		logic inv;
		logic quo_sat_sticky;
		logic quo_sat;
	} lane_flags_t;

	// One lane of a floating-point add
	typedef struct packed {
		logic [31:0] res;
		logic [31:0] trunc;
		logic        ovf;
		logic        unf;
		logic        inx;
		logic        grd;
		logic        sx;
	} fp_res_t;

	// Latched AHB address phase
	typedef struct packed {
		logic       sel;
		logic       wr;
		logic [7:0] addr;
	} ahb_ap_t;

	// Two lanes, index 1 is the high lane
	typedef logic [1:0][31:0] vec_t;

endpackage

// ===== testbench/core_issue_model.sv
/*
 Bus-side model of the core issue logic: an AHB-Lite master for single
 word transfers. Assumes one slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ns
`default_nettype none

module core_issue_model (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [31:0] hwdata
);
	// ------------------------------------------------------------
	// Idle bus from time zero
	// ------------------------------------------------------------
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// One transfer: address phase held until hready, then data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d; // Released data must not keep its last value
	endtask
endmodule

`default_nettype wire

// ===== testbench/testbench.sv
/*
 Self-checking bench of the paired-word vector block. Assumes the core
 issue model as bus master and the design's configuration header.
*/
`include "vec_alu_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module testbench
	import vec_alu_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        fp_irq;
	logic        round_irq;
	logic        busy;
	logic [31:0] rh;
	logic [31:0] rl;
	logic [31:0] scr;
	logic [31:0] v;
	int          mismatches;
	int          samples_checked;
	int          fp_n;
	int          rnd_n;
	int          n;

	// ------------------------------------------------------------
	// Design, bus master and clock
	// ------------------------------------------------------------
	paired_word_vector_alu_ops paired_word_vector_alu_ops_inst (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fp_irq(fp_irq),
		.round_irq(round_irq), .busy(busy));
	core_issue_model core_issue_model_inst (.hclk(hclk), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	always #50 hclk = ~hclk;

	// Interrupt pulses counted one per cycle
	always @(posedge hclk) begin
		if (fp_irq === 1'b1) fp_n++;
		if (round_irq === 1'b1) rnd_n++;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		core_issue_model_inst.xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		core_issue_model_inst.xfer(1'b0, a, 32'h0, q);
	endtask

	task automatic start_op(input op_t op, input logic [31:0] ah, al, bh, bl);
		wr(`A_OPA_HI, ah);
		wr(`A_OPA_LO, al);
		wr(`A_OPB_HI, bh);
		wr(`A_OPB_LO, bl);
		wr(`A_CMD, {29'h0, op});
	endtask

	// Poll until idle, then fetch both lanes and the status word
	task automatic finish_op();
		repeat (2) @(posedge hclk);
		for (int i = 0; i < 80; i++) begin
			rd(`A_STAT, v);
			if (v[2:0] === 3'b001) break;
		end
		rd(`A_RES_HI, rh);
		rd(`A_RES_LO, rl);
		rd(`A_SCR, scr);
	endtask

	task automatic one(input op_t op, input logic [31:0] ah, al, bh, bl, eh, el);
		start_op(op, ah, al, bh, bl);
		finish_op();
		check(rh, eh);
		check(rl, el);
	endtask

	task automatic finish_test();
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Signed divide: truncation, saturation, refused command while busy
	task automatic t_divs();
		wr(`A_SCR, 32'h0);
		start_op(OP_DIVS, 32'hfffffff9, 32'h80000000, 32'h2, 32'hffffffff);
		wr(`A_CMD, {29'h0, OP_EQV});
		rd(`A_STAT, v);
		check({29'h0, v[2:0]}, 32'h2);
		check({31'h0, busy}, 32'h1);
		finish_op();
		check(rh, 32'hfffffffd);
		check(rl, 32'h7fffffff);
		check({28'h0, scr[17:16], scr[1:0]}, 32'h3);
		one(OP_DIVS, 32'h0, 32'hfffffffb, 32'h0, 32'h0, 32'h7fffffff, 32'h80000000);
		check({28'h0, scr[17:16], scr[1:0]}, 32'hf);
		one(OP_DIVS, 32'h9, 32'h6, 32'h3, 32'h3, 32'h3, 32'h2);
		check({28'h0, scr[17:16], scr[1:0]}, 32'ha);
	endtask

	// Unsigned divide and the one-cycle operations other than add
	task automatic t_simple();
		wr(`A_SCR, 32'h0);
		one(OP_DIVU, 32'h5, 32'hffffffff, 32'h0, 32'h2, 32'hffffffff, 32'h7fffffff);
		check({28'h0, scr[17:16], scr[1:0]}, 32'hc);
		one(OP_EQV, 32'h12345678, 32'hffff0000, 32'h0f0f0f0f, 32'h00ff00ff,
			32'he2c4a688, 32'h00ffff00);
		one(OP_EXTSB, 32'h80, 32'h1234567f, 32'h0, 32'h0, 32'hffffff80, 32'h7f);
		one(OP_EXTSH, 32'h8001, 32'hffff7fff, 32'h0, 32'h0, 32'hffff8001, 32'h7fff);
		one(OP_ABS, 32'hbf800000, 32'h40000000, 32'h0, 32'h0, 32'h3f800000, 32'h40000000);
		one(OP_CFSF, 32'h0, 32'h0, 32'hc0000000, 32'h40000000, 32'hbf000000, 32'h3f000000);
		rd(8'h3c, v);
		check(v, 32'h0);
		check({30'h0, hreadyout, hresp}, 32'h2);
	endtask

	// Float add: special inputs, overflow, underflow in every mode
	task automatic t_add();
		wr(`A_SCR, 32'h0);
		one(OP_ADD, 32'h3f800000, 32'h7f800000, 32'h3f800000, 32'hff800000,
			32'h40000000, 32'h7f7fffff);
		check({29'h0, scr[4:2]}, 32'h1);
		check({31'h0, scr[18]}, 32'h0);
		one(OP_ADD, 32'h3f800000, 32'h3f800000, 32'hffc00000, 32'h3f800000,
			32'hff7fffff, 32'h40000000);
		wr(`A_SCR, 32'h0);
		one(OP_ADD, 32'h7f7fffff, 32'hff7fffff, 32'h7f7fffff, 32'hff7fffff,
			32'h7f7fffff, 32'hff7fffff);
		check({28'h0, scr[23], scr[21], scr[7], scr[5]}, 32'hf);
		for (int m = 0; m < 4; m++) begin
			wr(`A_SCR, 32'(m) << 12);
			one(OP_ADD, 32'h00c00000, 32'h00800000, 32'h80800000, 32'h80c00000,
				(m == 3) ? 32'h80000000 : 32'h0, (m == 3) ? 32'h80000000 : 32'h0);
			check({30'h0, scr[22], scr[6]}, 32'h3);
		end
	endtask

	// Enabled exceptions: destination kept or truncated, interrupts pulsed
	task automatic t_irq();
		wr(`A_SCR, 32'h100);
		one(OP_EXTSB, 32'h80, 32'h1234567f, 32'h0, 32'h0, 32'hffffff80, 32'h7f);
		n = fp_n;
		one(OP_ABS, 32'h7f800000, 32'h3f800000, 32'h0, 32'h0, 32'hffffff80, 32'h7f);
		check(32'(fp_n), 32'(n + 1));
		check({29'h0, scr[20:18]}, 32'h1);
		one(OP_ADD, 32'h7fc00000, 32'h3f800000, 32'h0, 32'h0, 32'hffffff80, 32'h7f);
		check(32'(fp_n), 32'(n + 2));
		wr(`A_SCR, 32'h200);
		one(OP_ADD, 32'h7f7fffff, 32'h3f800000, 32'h7f7fffff, 32'h3f800000,
			32'hffffff80, 32'h7f);
		check(32'(fp_n), 32'(n + 3));
		check({30'h0, scr[20:19]}, 32'h0);
		wr(`A_SCR, 32'h2800);
		n = rnd_n;
		one(OP_ADD, 32'h3f800000, 32'h3f800000, 32'h3f800000, 32'h30800000,
			32'h40000000, 32'h3f800000);
		check(32'(rnd_n), 32'(n + 1));
		check({30'h0, scr[4:3]}, 32'h2);
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		fp_n = 0;
		rnd_n = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_divs();
		t_simple();
		t_add();
		t_irq();
		finish_test();
	end

	// Cuts a hang short after 20000 cycles
	initial begin
		#2000000;
		mismatches++;
		finish_test();
	end
endmodule

`default_nettype wire
